// ===== inc/wmd_pkg.sv
// Package with register map, field positions, timing and carrier types.
package wmd_pkg;
  localparam logic [7:0] ADDR_EXT_ACC_BYTE2 = 8'hce;
  localparam logic [7:0] ADDR_EXT_ACC_BYTE3 = 8'hcf;
  localparam logic [7:0] ADDR_EXT_ACC_BYTE1 = 8'he6;
  localparam logic [7:0] ADDR_EXT_B_BYTE    = 8'he7;
  localparam logic [7:0] ADDR_AUX_CTRL_TWO  = 8'hf7;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam int         POS_WIDE_ARITH     = 0;
  localparam int         POS_LONG_DIVIDE    = 3;
  localparam logic [5:0] CYC_MUL8           = 6'h08;
  localparam logic [5:0] CYC_DIV8           = 6'h08;
  localparam logic [5:0] CYC_WIDE16         = 6'h10;
  localparam logic [5:0] CYC_LONG32         = 6'h20;

  typedef enum logic [2:0] {
    WMD_IDLE = 3'b001,
    WMD_BUSY = 3'b010,
    WMD_DONE = 3'b100
  } wmd_state_t;

  typedef enum logic [2:0] {
    WMD_OP_MUL8  = 3'b000,
    WMD_OP_DIV8  = 3'b001,
    WMD_OP_MUL16 = 3'b010,
    WMD_OP_DIV16 = 3'b011,
    WMD_OP_LONG_DIVIDE_MODE = 3'b100
  } wmd_op_t;

  // Special function register write port from the core.
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wmd_sfr_wr_t;

  // Operand and result bytes exchanged with the core.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
  } wmd_ab_t;
endpackage

// ===== test/wmd_core_model.sv
// Behavioural core model that writes SFRs and issues MUL AB and DIV AB.
`timescale 1ns/100ps
module wmd_core_model (
  input  wire logic             mclk,
  input  wire logic             done,
  input  wire wmd_pkg::wmd_ab_t ab_out,
  output wmd_pkg::wmd_sfr_wr_t  sfr_wr,
  output logic                  mul_start,
  output logic                  div_start,
  output wmd_pkg::wmd_ab_t      ab_in
);
  initial begin
    sfr_wr    = '0;
    mul_start = 1'b0;
    div_start = 1'b0;
    ab_in     = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released data is inverted so a stale value can never pass for a good one.
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    sfr_wr <= '{we: 1'b1, addr: addr, wdata: data};
    @(posedge mclk);
    sfr_wr <= '{we: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // Both widths go through the same two instructions.
  task automatic run(input logic is_div, input logic [7:0] a, b,
                     output wmd_pkg::wmd_ab_t res, output int cyc);
    @(posedge mclk);
    ab_in     <= '{acc: a, b: b};
    mul_start <= ~is_div;
    div_start <= is_div;
    @(posedge mclk);
    mul_start <= 1'b0;
    div_start <= 1'b0;
    ab_in     <= '{acc: ~a, b: ~b};
    cyc = 0;
    for (int i = 1; i <= 40 && cyc == 0; i++) begin
      @(posedge mclk);
      #1;
      if (done === 1'b1) cyc = i;
    end
    res = ab_out;
  endtask
endmodule

// ===== test/wmd_wide_mul_div_bench.sv
// Self-checking bench for the wide multiply/divide unit.
`timescale 1ns/100ps
module wmd_wide_mul_div_bench;
  logic                 mclk;
  logic                 srst;
  logic [7:0]           sfr_raddr;
  logic [7:0]           sfr_rdata;
  logic                 sfr_hit;
  logic                 mul_start;
  logic                 div_start;
  logic                 busy;
  logic                 done;
  logic                 overflow_flag;
  wmd_pkg::wmd_sfr_wr_t sfr_wr;
  wmd_pkg::wmd_ab_t     ab_in;
  wmd_pkg::wmd_ab_t     ab_out;
  int                   num_errors;
  int                   total_checks;
  int                   busy_cyc;

  localparam logic [7:0] REGS [5] = '{wmd_pkg::ADDR_EXT_ACC_BYTE2,
    wmd_pkg::ADDR_EXT_ACC_BYTE3, wmd_pkg::ADDR_EXT_ACC_BYTE1,
    wmd_pkg::ADDR_EXT_B_BYTE, wmd_pkg::ADDR_AUX_CTRL_TWO};
  localparam logic [7:0] EXT [4] = '{wmd_pkg::ADDR_EXT_ACC_BYTE1,
    wmd_pkg::ADDR_EXT_ACC_BYTE2, wmd_pkg::ADDR_EXT_ACC_BYTE3,
    wmd_pkg::ADDR_EXT_B_BYTE};
  // Each entry: mode, divide, A, B, ext byte1, byte2, byte3, ext B.
  // Of the overflowing wide operations OPS[3], OPS[5], OPS[6] and OPS[9], OPS[3] and OPS[6] are followed by clean ones on purpose.
  localparam logic [63:0] OPS [10] = '{
    64'h00_00_12_34_5a_6b_7c_8d, 64'h00_01_c8_07_5a_6b_7c_8d,
    64'h08_01_c8_07_5a_6b_7c_8d, 64'h01_00_34_56_12_6b_7c_00,
    64'h01_00_05_07_00_6b_7c_00, 64'h09_00_ff_ff_ff_6b_7c_ff,
    64'h01_01_34_00_12_6b_7c_00, 64'h01_01_34_07_12_6b_7c_00,
    64'h09_01_78_9a_56_34_12_01, 64'h09_01_78_00_56_34_12_00};

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Counts the edges at which busy stands since the last start.
  always @(posedge mclk) begin
    if (mul_start || div_start) begin
      busy_cyc <= 0;
    end else if (busy) begin
      busy_cyc <= busy_cyc + 1;
    end
  end

  wmd_wide_mul_div dut (
    .mclk          (mclk),
    .srst          (srst),
    .sfr_wr        (sfr_wr),
    .sfr_raddr     (sfr_raddr),
    .sfr_rdata     (sfr_rdata),
    .sfr_hit       (sfr_hit),
    .mul_start     (mul_start),
    .div_start     (div_start),
    .ab_in         (ab_in),
    .busy          (busy),
    .done          (done),
    .ab_out        (ab_out),
    .overflow_flag (overflow_flag)
  );

  wmd_core_model core (
    .mclk      (mclk),
    .done      (done),
    .ab_out    (ab_out),
    .sfr_wr    (sfr_wr),
    .mul_start (mul_start),
    .div_start (div_start),
    .ab_in     (ab_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    sfr_raddr <= addr;
    #1;
    data = sfr_rdata;
  endtask

  // Index map of e: 0 A, 1 B, 2 ext byte1, 3 byte2, 4 byte3, 5 ext B.
  task automatic check_op(input logic [63:0] op);
    logic [7:0]       m, dsel, a, b, rd;
    logic [7:0]       e [6];
    logic [31:0]      p, dd, q;
    logic [15:0]      dv, r;
    logic             eov;
    int               n, cyc;
    wmd_pkg::wmd_ab_t res;
    {m, dsel, a, b, e[2], e[3], e[4], e[5]} = op;
    core.sfr_write(wmd_pkg::ADDR_AUX_CTRL_TWO, m);
    for (int i = 0; i < 4; i++) core.sfr_write(EXT[i], e[i + 2]);
    core.run(dsel[0], a, b, res, cyc);
    e[0] = a;
    e[1] = b;
    eov  = 1'b0;
    if (!m[0]) begin
      n = 8;
      p = a * b;
      if (dsel[0]) begin
        e[0] = a / b;
        e[1] = a % b;
      end else begin
        {e[1], e[0]} = p[15:0];
        eov = p[15:8] != 8'h00;
      end
    end else if (!dsel[0]) begin
      n = 16;
      p = {e[2], a} * {e[5], b};
      {e[5], e[1], e[0], e[2]} = p;
      eov = p[31:16] != 16'h0000;
    end else begin
      n   = m[3] ? 32 : 16;
      dv  = {e[5], b};
      dd  = m[3] ? {e[4], e[3], e[2], a} : {16'h0000, e[2], a};
      eov = dv == 16'h0000;
      q   = eov ? '1 : dd / dv;
      r   = eov ? '1 : 16'(dd % dv);
      {e[1], e[5]} = r;
      if (m[3]) {e[0], e[2], e[3], e[4]} = q;
      else {e[0], e[2]} = q[15:0];
    end
    // The count stops at the edge that launches done, the edge just after which the
    // core samples it high; busy stands over the same span of edges.
    cmp("cycles", 8'(n + 1), 8'(cyc));
    if (cyc == 0) summarize();
    cmp("busy cycles", 8'(n + 1), 8'(busy_cyc));
    cmp("busy", 8'h00, {7'h00, busy});
    cmp("acc", e[0], res.acc);
    cmp("b", e[1], res.b);
    cmp("overflow", {7'h00, eov}, {7'h00, overflow_flag});
    for (int i = 0; i < 4; i++) begin
      sfr_read(EXT[i], rd);
      cmp("ext", e[i + 2], rd);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] rd;
    num_errors   = 0;
    total_checks = 0;
    srst         = 1'b1;
    sfr_raddr    = 8'h00;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      sfr_read(REGS[i], rd);
      cmp("reset", wmd_pkg::RESET_BYTE, rd);
      cmp("hit", 8'h01, {7'h00, sfr_hit});
      core.sfr_write(REGS[i], 8'ha5 ^ i[7:0]);
      sfr_read(REGS[i], rd);
      cmp("readback", 8'ha5 ^ i[7:0], rd);
    end
    sfr_read(8'hf8, rd);
    cmp("unmapped", 8'h00, rd);
    cmp("unmapped hit", 8'h00, {7'h00, sfr_hit});
    foreach (OPS[i]) check_op(OPS[i]);
    summarize();
  end
endmodule

// ===== verilog/wmd_byte_reg.sv
// One SFR byte that software writes and the arithmetic unit may overwrite.
`timescale 1ns/100ps
module wmd_byte_reg #(
  parameter logic [7:0] ADDR = 8'h00
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire wmd_pkg::wmd_sfr_wr_t sfr_wr,
  input  wire logic                 hw_we,
  input  wire logic [7:0]           hw_data,
  output logic      [7:0]           value
);
  typedef struct packed {
    logic [7:0] value;
  } wmd_breg_t;

  wmd_breg_t st;
  wmd_breg_t next_st;

  // The unit's result write wins over a software write in the same cycle,
  // since the core cannot issue an SFR write while an instruction finishes.
  always_comb begin
    next_st = st;
    if (sfr_wr.we && sfr_wr.addr == ADDR) begin
      next_st.value = sfr_wr.wdata;
    end
    if (hw_we) begin
      next_st.value = hw_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st.value <= wmd_pkg::RESET_BYTE;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;
endmodule

// ===== verilog/wmd_mode_reg.sv
// Auxiliary control register holding the two arithmetic mode bits.
`timescale 1ns/100ps
module wmd_mode_reg (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire wmd_pkg::wmd_sfr_wr_t sfr_wr,
  output logic      [7:0]           value,
  output logic                      wide_arith_mode,
  output logic                      long_divide_mode
);
  typedef struct packed {
    logic [7:0] value;
  } wmd_mreg_t;

  wmd_mreg_t st;
  wmd_mreg_t next_st;

  // Other bits of this register belong to other blocks; all eight are kept
  // here so a read returns what was written.
  always_comb begin
    next_st = st;
    if (sfr_wr.we && sfr_wr.addr == wmd_pkg::ADDR_AUX_CTRL_TWO) begin
      next_st.value = sfr_wr.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st.value <= wmd_pkg::RESET_BYTE;
    end else begin
      st <= next_st;
    end
  end

  assign value            = st.value;
  assign wide_arith_mode  = st.value[wmd_pkg::POS_WIDE_ARITH];
  assign long_divide_mode = st.value[wmd_pkg::POS_LONG_DIVIDE];
endmodule

// ===== verilog/wmd_wide_mul_div.sv
// Multiply/divide unit for MUL AB and DIV AB with 8, 16 and 32-bit modes.
`timescale 1ns/100ps
module wmd_wide_mul_div (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire wmd_pkg::wmd_sfr_wr_t sfr_wr,
  input  wire logic [7:0]           sfr_raddr,
  output logic      [7:0]           sfr_rdata,
  output logic                      sfr_hit,
  input  wire logic                 mul_start,
  input  wire logic                 div_start,
  input  wire wmd_pkg::wmd_ab_t     ab_in,
  output logic                      busy,
  output logic                      done,
  output wmd_pkg::wmd_ab_t          ab_out,
  output logic                      overflow_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] ext_acc_byte1;
  logic [7:0] ext_acc_byte2;
  logic [7:0] ext_acc_byte3;
  logic [7:0] ext_b_byte;
  logic [7:0] aux_value;
  logic       wide_arith_mode;
  logic       long_divide_mode;
  logic       res_we;
  logic [7:0] res_e1;
  logic [7:0] res_e2;
  logic [7:0] res_e3;
  logic [7:0] res_eb;

  wmd_byte_reg #(.ADDR(wmd_pkg::ADDR_EXT_ACC_BYTE1)) u_ext_acc_byte1 (
    .mclk    (mclk),
    .srst    (srst),
    .sfr_wr  (sfr_wr),
    .hw_we   (res_we),
    .hw_data (res_e1),
    .value   (ext_acc_byte1)
  );
  wmd_byte_reg #(.ADDR(wmd_pkg::ADDR_EXT_ACC_BYTE2)) u_ext_acc_byte2 (
    .mclk    (mclk),
    .srst    (srst),
    .sfr_wr  (sfr_wr),
    .hw_we   (res_we),
    .hw_data (res_e2),
    .value   (ext_acc_byte2)
  );
  wmd_byte_reg #(.ADDR(wmd_pkg::ADDR_EXT_ACC_BYTE3)) u_ext_acc_byte3 (
    .mclk    (mclk),
    .srst    (srst),
    .sfr_wr  (sfr_wr),
    .hw_we   (res_we),
    .hw_data (res_e3),
    .value   (ext_acc_byte3)
  );
  wmd_byte_reg #(.ADDR(wmd_pkg::ADDR_EXT_B_BYTE)) u_ext_b_byte (
    .mclk    (mclk),
    .srst    (srst),
    .sfr_wr  (sfr_wr),
    .hw_we   (res_we),
    .hw_data (res_eb),
    .value   (ext_b_byte)
  );
  wmd_mode_reg u_mode (
    .mclk             (mclk),
    .srst             (srst),
    .sfr_wr           (sfr_wr),
    .value            (aux_value),
    .wide_arith_mode  (wide_arith_mode),
    .long_divide_mode (long_divide_mode)
  );

  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 8'h00;
    unique case (sfr_raddr)
      wmd_pkg::ADDR_EXT_ACC_BYTE1: sfr_rdata = ext_acc_byte1;
      wmd_pkg::ADDR_EXT_ACC_BYTE2: sfr_rdata = ext_acc_byte2;
      wmd_pkg::ADDR_EXT_ACC_BYTE3: sfr_rdata = ext_acc_byte3;
      wmd_pkg::ADDR_EXT_B_BYTE:    sfr_rdata = ext_b_byte;
      wmd_pkg::ADDR_AUX_CTRL_TWO:  sfr_rdata = aux_value;
      default:                     sfr_hit   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and shift datapath.

  typedef struct packed {
    wmd_pkg::wmd_state_t state;
    wmd_pkg::wmd_op_t    op;
    logic [5:0]          cnt;
    logic [31:0]         acc;
    logic [31:0]         num;
    logic [15:0]         den;
    logic [16:0]         rem;
    logic                dz;
    logic [7:0]          r_a;
    logic [7:0]          r_b;
    logic [7:0]          r_e1;
    logic [7:0]          r_e2;
    logic [7:0]          r_e3;
    logic [7:0]          r_eb;
    logic                ov;
    logic                wr;
  } wmd_core_t;

  wmd_core_t st;
  wmd_core_t next_st;

  logic [16:0] trial;
  logic [16:0] shifted;
  logic [31:0] prod;
  logic [31:0] quot;
  logic [15:0] remw;
  logic        last;

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    shifted = {st.rem[15:0], st.num[31]};
    trial   = shifted - {1'b0, st.den};
    prod    = st.acc;
    quot    = st.num;
    remw    = st.rem[15:0];
    last    = (st.cnt == 6'h01);
    unique case (st.state)
      wmd_pkg::WMD_IDLE: begin
        if (mul_start || div_start) begin
          next_st.state = wmd_pkg::WMD_BUSY;
          next_st.rem   = 17'h00000;
          next_st.acc   = 32'h00000000;
          // The long-divide bit is ignored unless wide mode is on.
          if (!wide_arith_mode) begin
            next_st.op  = mul_start ? wmd_pkg::WMD_OP_MUL8
                                    : wmd_pkg::WMD_OP_DIV8;
            next_st.cnt = mul_start ? wmd_pkg::CYC_MUL8 : wmd_pkg::CYC_DIV8;
            next_st.num = {ab_in.acc, 24'h000000};
            next_st.den = {8'h00, ab_in.b};
          end else if (mul_start) begin
            next_st.op  = wmd_pkg::WMD_OP_MUL16;
            next_st.cnt = wmd_pkg::CYC_WIDE16;
            next_st.num = {ext_acc_byte1, ab_in.acc, 16'h0000};
            next_st.den = {ext_b_byte, ab_in.b};
          end else if (!long_divide_mode) begin
            next_st.op  = wmd_pkg::WMD_OP_DIV16;
            next_st.cnt = wmd_pkg::CYC_WIDE16;
            next_st.num = {ext_acc_byte1, ab_in.acc, 16'h0000};
            next_st.den = {ext_b_byte, ab_in.b};
          end else begin
            next_st.op  = wmd_pkg::WMD_OP_LONG_DIVIDE_MODE;
            next_st.cnt = wmd_pkg::CYC_LONG32;
            next_st.num = {ext_acc_byte3, ext_acc_byte2,
                           ext_acc_byte1, ab_in.acc};
            next_st.den = {ext_b_byte, ab_in.b};
          end
          next_st.dz = (ext_b_byte == 8'h00 || !wide_arith_mode)
                       && ab_in.b == 8'h00;
        end
      end
      wmd_pkg::WMD_BUSY: begin
        // One bit per clock: this keeps the area small at the cost of
        // the documented multi-cycle latency.
        if (st.op == wmd_pkg::WMD_OP_MUL8 ||
            st.op == wmd_pkg::WMD_OP_MUL16) begin
          next_st.acc = {st.acc[30:0], 1'b0}
                        + (st.num[31] ? {16'h0000, st.den} : 32'h00000000);
          next_st.num = {st.num[30:0], 1'b0};
        end else if (!trial[16]) begin
          next_st.rem = trial;
          next_st.num = {st.num[30:0], 1'b1};
        end else begin
          next_st.rem = shifted;
          next_st.num = {st.num[30:0], 1'b0};
        end
        next_st.cnt = st.cnt - 6'h01;
        if (last) begin
          next_st.state = wmd_pkg::WMD_DONE;
        end
      end
      wmd_pkg::WMD_DONE: begin
        next_st.state = wmd_pkg::WMD_IDLE;
        next_st.wr    = 1'b1;
        prod = st.acc;
        quot = st.dz ? 32'hffffffff : st.num;
        remw = st.dz ? 16'hffff : st.rem[15:0];
        next_st.r_e2 = ext_acc_byte2;
        next_st.r_e3 = ext_acc_byte3;
        next_st.r_e1 = ext_acc_byte1;
        next_st.r_eb = ext_b_byte;
        unique case (st.op)
          wmd_pkg::WMD_OP_MUL8: begin
            next_st.r_a = prod[7:0];
            next_st.r_b = prod[15:8];
            next_st.ov  = prod[15:8] != 8'h00;
          end
          wmd_pkg::WMD_OP_DIV8: begin
            next_st.r_a = quot[7:0];
            next_st.r_b = remw[7:0];
            next_st.ov  = st.dz;
          end
          wmd_pkg::WMD_OP_MUL16: begin
            next_st.r_e1 = prod[7:0];
            next_st.r_a  = prod[15:8];
            next_st.r_b  = prod[23:16];
            next_st.r_eb = prod[31:24];
            next_st.ov   = prod[31:16] != 16'h0000;
          end
          wmd_pkg::WMD_OP_DIV16: begin
            next_st.r_e1 = quot[7:0];
            next_st.r_a  = quot[15:8];
            next_st.r_eb = remw[7:0];
            next_st.r_b  = remw[15:8];
            next_st.ov   = st.dz;
          end
          default: begin
            next_st.r_e3 = quot[7:0];
            next_st.r_e2 = quot[15:8];
            next_st.r_e1 = quot[23:16];
            next_st.r_a  = quot[31:24];
            next_st.r_eb = remw[7:0];
            next_st.r_b  = remw[15:8];
            next_st.ov   = st.dz;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st.state <= wmd_pkg::WMD_IDLE;
      st.op    <= wmd_pkg::WMD_OP_MUL8;
      st.cnt   <= 6'h00;
      st.acc   <= 32'h00000000;
      st.num   <= 32'h00000000;
      st.den   <= 16'h0000;
      st.rem   <= 17'h00000;
      st.dz    <= 1'b0;
      st.r_a   <= 8'h00;
      st.r_b   <= 8'h00;
      st.r_e1  <= 8'h00;
      st.r_e2  <= 8'h00;
      st.r_e3  <= 8'h00;
      st.r_eb  <= 8'h00;
      st.ov    <= 1'b0;
      st.wr    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // The expansion bytes load at the same edge as done, so a start issued
  // in the done cycle already sees the new result bytes as operands.
  assign res_we        = next_st.wr;
  assign res_e1        = next_st.r_e1;
  assign res_e2        = next_st.r_e2;
  assign res_e3        = next_st.r_e3;
  assign res_eb        = next_st.r_eb;
  assign busy          = st.state != wmd_pkg::WMD_IDLE;
  assign done          = st.wr;
  assign ab_out.acc    = st.r_a;
  assign ab_out.b      = st.r_b;
  assign overflow_flag = st.ov;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_mul16_cycles: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_IDLE && mul_start && wide_arith_mode)
    |-> ##17 st.state == wmd_pkg::WMD_DONE)
    else $error("wide multiply latency wrong");

  chk_div16_cycles: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_IDLE && div_start && wide_arith_mode
     && !long_divide_mode) |-> ##17 st.state == wmd_pkg::WMD_DONE)
    else $error("wide divide latency wrong");

  chk_long_divide_mode_cycles: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_IDLE && div_start && wide_arith_mode
     && long_divide_mode) |-> ##33 st.state == wmd_pkg::WMD_DONE)
    else $error("long divide latency wrong");

  chk_mode_select: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_IDLE && mul_start && wide_arith_mode)
    |=> st.op == wmd_pkg::WMD_OP_MUL16)
    else $error("long-divide bit changed multiply width");

  chk_narrow_op: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_IDLE && (mul_start || div_start)
     && !wide_arith_mode) |=> st.cnt == wmd_pkg::CYC_MUL8)
    else $error("narrow mode not selected");

  chk_mul16_ov: assert property (@(posedge mclk)
    disable iff (srst)
    (done && st.op == wmd_pkg::WMD_OP_MUL16)
    |-> overflow_flag == (ab_out.b != 8'h00 || ext_b_byte != 8'h00))
    else $error("wide multiply overflow wrong");

  chk_div_zero_ov: assert property (@(posedge mclk)
    disable iff (srst)
    (st.state == wmd_pkg::WMD_DONE && st.op != wmd_pkg::WMD_OP_MUL16
     && st.op != wmd_pkg::WMD_OP_MUL8)
    |=> overflow_flag == $past(st.dz))
    else $error("divide overflow not tied to zero divisor");

  // A start in the done cycle is legal, so busy may rise right after done.
  chk_done_pulse: assert property (@(posedge mclk)
    disable iff (srst)
    done |=> !done && busy == $past(mul_start || div_start))
    else $error("done not a single pulse");
endmodule
